// File: hw/readout_pkg.sv
`default_nettype none
package readout_pkg;
    // Link and slice geometry
    localparam int LINK_W = 20;
    localparam int DAQ_STREAMS = 20;
    localparam int HIT_W = 48;
    localparam int BCN_W = 12;
    localparam int OWN_W = 60;
    localparam int ROI_STREAMS = 16;
    localparam int PIPE_DEPTH = 128;
    localparam int PTR_W = 7;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    localparam int ENTRY_W = 61;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Per-stream bit positions inside one DAQ slice, plus the region external word count
    localparam logic [2:0] DAQ_OWN_FIRST = 3'h4;
    localparam logic [2:0] DAQ_PAR_BIT = 3'h7;
    localparam logic [2:0] DAQ_CHAIN_BIT = 3'h6;
    localparam logic [2:0] ROI_EXT_WORDS = 3'h4;

    // Slice count limits and dead time floor
    localparam logic [2:0] SLICE_MIN = 3'h1;
    localparam logic [2:0] SLICE_MAX = 3'h5;
    localparam logic [7:0] DEAD_MIN = 8'h03;

    // Register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_HIT_OFFSET = 4'h1;
    localparam logic [3:0] REG_DEAD_TIME = 4'h2;
    localparam logic [3:0] REG_CROSSING = 4'h3;
    localparam logic [3:0] REG_EVENTS = 4'h4;
    localparam logic [3:0] REG_SPY_ADDR = 4'h5;
    localparam logic [3:0] REG_SPY_LO = 4'h6;
    localparam logic [3:0] REG_SPY_MID = 4'h7;
    localparam logic [3:0] REG_SPY_HI = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;

    // Field positions
    localparam int CTRL_SLICE_LSB = 0;
    localparam int CTRL_PLAY_BIT = 4;
    localparam int CTRL_ARST_BIT = 5;
    localparam int STAT_LOST_BIT = 0;
    localparam int STAT_OVF_BIT = 1;
    localparam int STAT_DAQ_EMPTY_BIT = 2;
    localparam int STAT_ROI_EMPTY_BIT = 3;

    // Reset values
    localparam logic [2:0] SLICE_RST = 3'h1;
    localparam logic [7:0] DEAD_RST = 8'h03;
    localparam logic [6:0] OFFSET_RST = 7'h00;

    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT, ST_DEAD} seq_state_t;
endpackage
`default_nettype wire

// File: hw/readout_sequencer.sv
// Contract
// - Accept starts readout of all twenty streams
// - Slice: 80 external bits plus 60 own
// - Software slice count, 1 to 5
// - Hit pipeline written every crossing outside playback, own counters
// - Pipeline read feeds FIFO, sixteen 3-bit shifters
// - Separate software hit read offset preload
// - Crossing number split over four 3-bit shifters
// - Hit pipeline readable as spy, playback source
// - Region streams relayed onto link bits 0..15
// - Region side: crossing counter and FIFO only
// - Region crossing number parallel on bits 0..11
// - Region link bits 16..19 held zero
// - One region slice per accept
// - Both links carry 20-bit words always
// - Valid strobe frames slice words continuously
// - Strobe held across slices of one accept
// - Programmable dead time, at least three ticks
// - Output stage retimes words onto link
// - Timing strobes enter the sequencer directly
// - Crossing number pushed per read-enable tick
// - Crossing counter cleared by counter-clear strobe
// - After external bits, switch to own bits
// - One parity bit per stream per slice
`default_nettype none
module readout_sequencer
    import readout_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic level1_accept_in,
    input wire logic crossing_counter_clear_in,
    input wire logic event_counter_clear_in,
    input wire logic [HIT_W-1:0] hit_result_in,
    input wire logic [DAQ_STREAMS-1:0] serialiser_stream_in,
    input wire logic [ROI_STREAMS-1:0] cluster_module_stream_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    output logic pipeline_read_enable_out,
    output logic shifter_load_out,
    output logic region_of_interest_read_enable_out,
    output logic region_of_interest_shifter_load_out,
    output logic [LINK_W-1:0] daq_link_data_out,
    output logic data_valid_strobe_n_out,
    output logic [LINK_W-1:0] region_of_interest_link_data_out,
    output logic region_of_interest_data_valid_strobe_n_out
);

    typedef struct packed {
        logic [PTR_W-1:0] wr_ptr, rd_ptr;
        logic [BCN_W-1:0] crossing_number;
        logic [15:0] events;
        logic [2:0] slice_cfg;
        logic playback;
        logic [6:0] hit_offset;
        logic [7:0] dead_cfg;
        logic [PTR_W-1:0] spy_addr;
        logic [31:0] spy_stage;
        logic [DATA_W-1:0] rdata;
        logic lost, overflow;
        // DAQ read-out side
        logic [2:0] seq_cnt;
        logic rd_en, rd_last;
        logic [BCN_W-1:0] bcn_lat;
        logic [FIFO_DEPTH-1:0][ENTRY_W-1:0] fifo;
        logic [FIFO_AW:0] f_wp, f_rp;
        seq_state_t dstate;
        logic [2:0] bitcnt;
        logic [HIT_W-1:0] hsh;
        logic [BCN_W-1:0] bsh;
        logic last, chain;
        logic [DAQ_STREAMS-1:0] par;
        logic [7:0] dead_cnt;
        logic load;
        logic [LINK_W-1:0] dword;
        logic dv_n;
        // Region read-out side
        logic roi_rd_en;
        logic [BCN_W-1:0] roi_lat;
        logic [FIFO_DEPTH-1:0][BCN_W-1:0] rfifo;
        logic [FIFO_AW:0] r_wp, r_rp;
        seq_state_t rstate;
        logic [2:0] rcnt;
        logic [BCN_W-1:0] rbsh;
        logic [ROI_STREAMS-1:0] rpar;
        logic [7:0] rdead_cnt;
        logic rload;
        logic [LINK_W-1:0] rword;
        logic rdv_n;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic [HIT_W-1:0] hit_mem [PIPE_DEPTH];
    logic spy_commit;

    // Hit pipeline: real-time writes unless playback freezes them for software loading
    always_ff @(posedge mclk_in) begin
        if (clk_en_in) begin
            if (spy_commit) begin
                hit_mem[s_reg.spy_addr] <= {reg_wdata_in, s_reg.spy_stage};
            end else if (!s_reg.playback) begin
                hit_mem[s_reg.wr_ptr] <= hit_result_in;
            end
        end
    end

    // All control state; clock enable freezes everything
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= '0;
            s_reg.slice_cfg <= SLICE_RST;
            s_reg.dead_cfg <= DEAD_RST;
            s_reg.hit_offset <= OFFSET_RST;
            s_reg.rd_ptr <= OFFSET_RST;
            s_reg.dstate <= ST_IDLE;
            s_reg.rstate <= ST_IDLE;
            s_reg.dv_n <= 1'b1;
            s_reg.rdv_n <= 1'b1;
        end else if (clk_en_in) begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        logic [OWN_W-1:0] own;
        logic [DAQ_STREAMS-1:0] word;
        logic [2:0] slices;
        logic [7:0] dead_eff;
        logic f_empty, f_full, r_empty, r_full, lost_set, ovf_set;
        logic [ENTRY_W-1:0] head;
        own = '0;
        word = '0;
        slices = '0;
        dead_eff = '0;
        head = '0;
        lost_set = 1'b0;
        ovf_set = 1'b0;
        s_next = s_reg;
        s_next.load = 1'b0;
        s_next.rload = 1'b0;
        spy_commit = 1'b0;

        f_empty = (s_reg.f_wp == s_reg.f_rp);
        f_full = (s_reg.f_wp[FIFO_AW] != s_reg.f_rp[FIFO_AW]) &&
                 (s_reg.f_wp[FIFO_AW-1:0] == s_reg.f_rp[FIFO_AW-1:0]);
        r_empty = (s_reg.r_wp == s_reg.r_rp);
        r_full = (s_reg.r_wp[FIFO_AW] != s_reg.r_rp[FIFO_AW]) &&
                 (s_reg.r_wp[FIFO_AW-1:0] == s_reg.r_rp[FIFO_AW-1:0]);
        head = s_reg.fifo[s_reg.f_rp[FIFO_AW-1:0]];

        // Out-of-range slice counts are pulled to the nearest legal value
        slices = (s_reg.slice_cfg < SLICE_MIN) ? SLICE_MIN : s_reg.slice_cfg;
        slices = (slices > SLICE_MAX) ? SLICE_MAX : slices;
        dead_eff = (s_reg.dead_cfg < DEAD_MIN) ? DEAD_MIN : s_reg.dead_cfg;

        // Crossing counter; strobes come straight from the timing receiver pins
        s_next.crossing_number = crossing_counter_clear_in ? '0 : s_reg.crossing_number + 12'h001;
        if (event_counter_clear_in) begin
            s_next.events = '0;
        end else if (level1_accept_in) begin
            s_next.events = s_reg.events + 16'h0001;
        end

        // Write counter runs every crossing; read counter steps on read-enable ticks only
        s_next.wr_ptr = s_reg.wr_ptr + 7'h01;
        if (s_reg.rd_en) begin
            s_next.rd_ptr = s_reg.rd_ptr + 7'h01;
        end

        // Accept: latch crossing number and arm the read-enable run
        if (level1_accept_in && s_reg.seq_cnt == 3'h0) begin
            s_next.seq_cnt = slices;
            s_next.bcn_lat = s_reg.crossing_number;
        end else if (s_reg.seq_cnt != 3'h0) begin
            lost_set = level1_accept_in; // Dropped, the run keeps counting
            s_next.seq_cnt = s_reg.seq_cnt - 3'h1;
        end
        s_next.rd_en = (s_reg.seq_cnt != 3'h0);
        s_next.rd_last = (s_reg.seq_cnt == 3'h1);

        // Each read-enable tick moves one hit word and the crossing number into the FIFO
        if (s_reg.rd_en) begin
            if (f_full) begin
                ovf_set = 1'b1;
            end else begin
                s_next.fifo[s_reg.f_wp[FIFO_AW-1:0]] = {s_reg.rd_last, s_reg.bcn_lat,
                                                        hit_mem[s_reg.rd_ptr]};
                s_next.f_wp = s_reg.f_wp + 4'h1;
            end
        end

        // DAQ stream words: external bits, then own 3-bit chunks, then parity
        own = {s_reg.bsh, s_reg.hsh};
        for (int i = 0; i < DAQ_STREAMS; i++) begin
            if (s_reg.bitcnt < DAQ_OWN_FIRST) begin
                word[i] = serialiser_stream_in[i];
            end else if (s_reg.bitcnt < DAQ_PAR_BIT) begin
                word[i] = own[3 * i + int'(s_reg.bitcnt - DAQ_OWN_FIRST)];
            end else begin
                word[i] = s_reg.par[i];
            end
        end

        s_next.dword = '0;
        s_next.dv_n = 1'b1;
        case (s_reg.dstate)
            ST_IDLE: begin
                if (!f_empty) begin
                    s_next.load = 1'b1;
                    s_next.dstate = ST_LOAD;
                end
            end
            ST_LOAD: begin
                s_next.hsh = head[HIT_W-1:0];
                s_next.bsh = head[HIT_W+BCN_W-1:HIT_W];
                s_next.last = head[ENTRY_W-1];
                s_next.f_rp = s_reg.f_rp + 4'h1;
                s_next.bitcnt = 3'h0;
                s_next.chain = 1'b0;
                s_next.dstate = ST_SHIFT;
            end
            ST_SHIFT: begin
                s_next.dword = word;
                s_next.dv_n = 1'b0;
                s_next.bitcnt = s_reg.bitcnt + 3'h1;
                s_next.par = (s_reg.bitcnt == 3'h0) ? word : (s_reg.par ^ word);
                // Next slice of the same accept loads one tick early so the strobe never drops
                if (s_reg.bitcnt == DAQ_CHAIN_BIT && !s_reg.last && !f_empty) begin
                    s_next.load = 1'b1;
                    s_next.chain = 1'b1;
                end
                if (s_reg.bitcnt == DAQ_PAR_BIT) begin
                    if (s_reg.chain) begin
                        s_next.hsh = head[HIT_W-1:0];
                        s_next.bsh = head[HIT_W+BCN_W-1:HIT_W];
                        s_next.last = head[ENTRY_W-1];
                        s_next.f_rp = s_reg.f_rp + 4'h1;
                        s_next.chain = 1'b0;
                    end else begin
                        s_next.dead_cnt = dead_eff;
                        s_next.dstate = ST_DEAD;
                    end
                end
            end
            ST_DEAD: begin
                s_next.dead_cnt = s_reg.dead_cnt - 8'h01;
                if (s_reg.dead_cnt <= 8'h01) begin
                    s_next.dstate = ST_IDLE;
                end
            end
            default: begin
                s_next.dstate = ST_IDLE;
            end
        endcase

        // Region side: one read-enable tick and one crossing number per accept
        s_next.roi_rd_en = level1_accept_in;
        if (level1_accept_in) begin
            s_next.roi_lat = s_reg.crossing_number;
        end
        if (s_reg.roi_rd_en) begin
            if (r_full) begin
                ovf_set = 1'b1;
            end else begin
                s_next.rfifo[s_reg.r_wp[FIFO_AW-1:0]] = s_reg.roi_lat;
                s_next.r_wp = s_reg.r_wp + 4'h1;
            end
        end

        s_next.rword = '0;
        s_next.rdv_n = 1'b1;
        case (s_reg.rstate)
            ST_IDLE: begin
                if (!r_empty) begin
                    s_next.rload = 1'b1;
                    s_next.rstate = ST_LOAD;
                end
            end
            ST_LOAD: begin
                s_next.rbsh = s_reg.rfifo[s_reg.r_rp[FIFO_AW-1:0]];
                s_next.r_rp = s_reg.r_rp + 4'h1;
                s_next.rcnt = 3'h0;
                s_next.rpar = '0;
                s_next.rstate = ST_SHIFT;
            end
            ST_SHIFT: begin
                s_next.rdv_n = 1'b0;
                s_next.rcnt = s_reg.rcnt + 3'h1;
                if (s_reg.rcnt < ROI_EXT_WORDS) begin
                    s_next.rword[ROI_STREAMS-1:0] = cluster_module_stream_in;
                    s_next.rpar = s_reg.rpar ^ cluster_module_stream_in;
                end else if (s_reg.rcnt == ROI_EXT_WORDS) begin
                    s_next.rword[BCN_W-1:0] = s_reg.rbsh;
                    s_next.rpar[BCN_W-1:0] = s_reg.rpar[BCN_W-1:0] ^ s_reg.rbsh;
                end else begin
                    s_next.rword[ROI_STREAMS-1:0] = s_reg.rpar;
                    s_next.rdead_cnt = dead_eff;
                    s_next.rstate = ST_DEAD;
                end
            end
            ST_DEAD: begin
                s_next.rdead_cnt = s_reg.rdead_cnt - 8'h01;
                if (s_reg.rdead_cnt <= 8'h01) begin
                    s_next.rstate = ST_IDLE;
                end
            end
            default: begin
                s_next.rstate = ST_IDLE;
            end
        endcase

        // Register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                REG_CTRL: begin
                    s_next.slice_cfg = reg_wdata_in[CTRL_SLICE_LSB +: 3];
                    s_next.playback = reg_wdata_in[CTRL_PLAY_BIT];
                    if (reg_wdata_in[CTRL_ARST_BIT]) begin
                        s_next.wr_ptr = '0;
                        s_next.rd_ptr = s_reg.hit_offset;
                    end
                end
                REG_HIT_OFFSET: s_next.hit_offset = reg_wdata_in[PTR_W-1:0];
                REG_DEAD_TIME: s_next.dead_cfg = reg_wdata_in[7:0];
                REG_SPY_ADDR: s_next.spy_addr = reg_wdata_in[PTR_W-1:0];
                REG_SPY_LO: s_next.spy_stage[15:0] = reg_wdata_in;
                REG_SPY_MID: s_next.spy_stage[31:16] = reg_wdata_in;
                REG_SPY_HI: begin
                    // Top word commits only in playback, so live capture is never corrupted
                    if (s_reg.playback) begin
                        spy_commit = 1'b1;
                        s_next.spy_addr = s_reg.spy_addr + 7'h01;
                    end
                end
                REG_STATUS: begin
                    s_next.lost = s_reg.lost & ~reg_wdata_in[STAT_LOST_BIT];
                    s_next.overflow = s_reg.overflow & ~reg_wdata_in[STAT_OVF_BIT];
                end
                default: begin
                end
            endcase
        end
        // Sticky error flags: a new event beats a clear in the same tick
        s_next.lost = s_next.lost | lost_set;
        s_next.overflow = s_next.overflow | ovf_set;

        // Read data stand in the cycle after the strobe only
        s_next.rdata = '0;
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_CTRL: s_next.rdata = {10'h000, 1'b0, s_reg.playback, 1'b0, s_reg.slice_cfg};
                REG_HIT_OFFSET: s_next.rdata = {9'h000, s_reg.hit_offset};
                REG_DEAD_TIME: s_next.rdata = {8'h00, s_reg.dead_cfg};
                REG_CROSSING: s_next.rdata = {4'h0, s_reg.crossing_number};
                REG_EVENTS: s_next.rdata = s_reg.events;
                REG_SPY_ADDR: s_next.rdata = {9'h000, s_reg.spy_addr};
                REG_SPY_LO: s_next.rdata = hit_mem[s_reg.spy_addr][15:0];
                REG_SPY_MID: s_next.rdata = hit_mem[s_reg.spy_addr][31:16];
                REG_SPY_HI: s_next.rdata = hit_mem[s_reg.spy_addr][47:32];
                REG_STATUS: begin
                    s_next.rdata[STAT_LOST_BIT] = s_reg.lost;
                    s_next.rdata[STAT_OVF_BIT] = s_reg.overflow;
                    s_next.rdata[STAT_DAQ_EMPTY_BIT] = f_empty;
                    s_next.rdata[STAT_ROI_EMPTY_BIT] = r_empty;
                end
                default: s_next.rdata = '0;
            endcase
        end
    end

    // Outputs straight from the state register; one clock, so the link stage is a plain register
    assign reg_rdata_out = s_reg.rdata;
    assign pipeline_read_enable_out = s_reg.rd_en;
    assign shifter_load_out = s_reg.load;
    assign region_of_interest_read_enable_out = s_reg.roi_rd_en;
    assign region_of_interest_shifter_load_out = s_reg.rload;
    assign daq_link_data_out = s_reg.dword;
    assign data_valid_strobe_n_out = s_reg.dv_n;
    assign region_of_interest_link_data_out = s_reg.rword;
    assign region_of_interest_data_valid_strobe_n_out = s_reg.rdv_n;

endmodule
`default_nettype wire

// File: tb/link_receiver.sv
`default_nettype none
module link_receiver
    import readout_pkg::*;
#(
    parameter int SLICE = 8
)(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [LINK_W-1:0] word_in,
    input wire logic valid_n_in,
    output logic done_out,
    output logic [7:0] words_out,
    output logic [7:0] parity_err_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [LINK_W-1:0] acc_reg;
    logic [7:0] cnt_reg;
    logic [3:0] idx_reg;
    // Counts framed words per frame; words with the strobe high are dropped
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_reg <= '0;
            cnt_reg <= 8'h00;
            idx_reg <= 4'h0;
            done_out <= 1'b0;
            words_out <= 8'h00;
            parity_err_out <= 8'h00;
        end else if (!valid_n_in) begin
            cnt_reg <= cnt_reg + 8'h01;
            done_out <= 1'b0;
            if (idx_reg == 4'(SLICE - 1)) begin
                if (word_in !== acc_reg) parity_err_out <= parity_err_out + 8'h01;
                acc_reg <= '0;
                idx_reg <= 4'h0;
            end else begin
                acc_reg <= acc_reg ^ word_in;
                idx_reg <= idx_reg + 4'h1;
            end
        end else begin
            done_out <= (cnt_reg != 8'h00);
            words_out <= cnt_reg;
            cnt_reg <= 8'h00;
            acc_reg <= '0;
            idx_reg <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// File: tb/readout_sequencer_bench.sv
`default_nettype none
module readout_sequencer_bench
    import readout_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in;
    logic rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic level1_accept_in = 1'b0;
    logic crossing_counter_clear_in = 1'b0;
    logic event_counter_clear_in = 1'b0;
    logic [HIT_W-1:0] hit_result_in = '0;
    logic [DAQ_STREAMS-1:0] serialiser_stream_in = '0;
    logic [ROI_STREAMS-1:0] cluster_module_stream_in = '0;
    logic [ADDR_W-1:0] reg_addr_in = '0;
    logic [DATA_W-1:0] reg_wdata_in = '0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [DATA_W-1:0] reg_rdata_out;
    logic pipeline_read_enable_out, shifter_load_out;
    logic region_of_interest_read_enable_out, region_of_interest_shifter_load_out;
    logic [LINK_W-1:0] daq_link_data_out, region_of_interest_link_data_out;
    logic data_valid_strobe_n_out, region_of_interest_data_valid_strobe_n_out;
    logic daq_done, roi_done, rd_q;
    logic [7:0] daq_len, roi_len, daq_err, roi_err;
    logic [31:0] rnd = 32'h0001_0439;
    logic [2:0] sl [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
    logic [15:0] reg_q[$];
    logic [7:0] daq_q[$];
    logic [7:0] roi_q[$];
    int n_mismatch = 0;
    int samples_checked = 0;

    readout_sequencer uut (.*);
    link_receiver #(.SLICE(8)) daq_rx (.mclk_in(mclk_in), .rst_in(rst_in), .word_in(daq_link_data_out),
        .valid_n_in(data_valid_strobe_n_out), .done_out(daq_done), .words_out(daq_len), .parity_err_out(daq_err));
    link_receiver #(.SLICE(6)) roi_rx (.mclk_in(mclk_in), .rst_in(rst_in),
        .word_in(region_of_interest_link_data_out), .valid_n_in(region_of_interest_data_valid_strobe_n_out),
        .done_out(roi_done), .words_out(roi_len), .parity_err_out(roi_err));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: register %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_len(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: frame of %0d words, expected %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        reg_q.push_back(exp);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    // Zero words means the read run is expected to drop this accept
    task automatic accept(input int words);
        if (words > 0) daq_q.push_back(8'(words));
        roi_q.push_back(8'h06);
        level1_accept_in <= 1'b1;
        @(posedge mclk_in);
        level1_accept_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    // Bounded wait for outstanding frames, then room for the dead time
    task automatic settle();
        for (int i = 0; i < 600 && (daq_q.size() + roi_q.size()) > 0; i++) @(posedge mclk_in);
        repeat (16) @(posedge mclk_in);
    endtask

    task automatic results();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // 25 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    // Random stream and hit data on every rising edge
    always @(posedge mclk_in) begin
        rnd <= lfsr(rnd);
        serialiser_stream_in <= rnd[19:0];
        cluster_module_stream_in <= rnd[31:16];
        hit_result_in <= {rnd[15:0], rnd};
        rd_q <= reg_rd_in;
    end

    // Results are taken half a cycle after they appear
    always @(negedge mclk_in) begin
        if (rd_q) check_reg(reg_rdata_out, reg_q.pop_front());
        if (daq_done) check_len(daq_len, daq_q.pop_front());
        if (roi_done) check_len(roi_len, roi_q.pop_front());
    end

    initial begin
        int n;
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        rd(REG_DEAD_TIME, 16'h0003);
        rd(REG_HIT_OFFSET, 16'h0000);
        rd(4'hF, 16'h0000);
        event_counter_clear_in <= 1'b1;
        crossing_counter_clear_in <= 1'b1;
        @(posedge mclk_in);
        event_counter_clear_in <= 1'b0;
        crossing_counter_clear_in <= 1'b0;
        @(posedge mclk_in);
        rd(REG_CROSSING, 16'h0001);
        for (int i = 0; i < 5; i++) begin
            n = (sl[i] == 3'h0) ? 1 : ((sl[i] > 3'h5) ? 5 : int'(sl[i]));
            wr(REG_CTRL, {13'h0000, sl[i]});
            accept(8 * n);
            settle();
        end
        rd(REG_EVENTS, 16'h0005);
        wr(REG_DEAD_TIME, 16'h0001);
        accept(40);
        settle();
        wr(REG_DEAD_TIME, 16'h000A);
        wr(REG_CTRL, 16'h0003);
        accept(24);
        accept(0);
        settle();
        rd(REG_STATUS, 16'h000D);
        wr(REG_CTRL, 16'h0011);
        wr(REG_SPY_ADDR, 16'h0005);
        wr(REG_SPY_LO, 16'h1234);
        wr(REG_SPY_MID, 16'h5678);
        wr(REG_SPY_HI, 16'h9ABC);
        wr(REG_SPY_ADDR, 16'h0005);
        rd(REG_SPY_LO, 16'h1234);
        rd(REG_SPY_MID, 16'h5678);
        rd(REG_SPY_HI, 16'h9ABC);
        accept(8);
        settle();
        check_reg({8'h00, daq_err}, 16'h0000);
        check_reg({8'h00, roi_err}, 16'h0000);
        check_reg(16'(daq_q.size() + roi_q.size()), 16'h0000);
        results();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #400000;
        n_mismatch++;
        results();
    end
endmodule

bind readout_sequencer seq_checker u_chk (.*);
`default_nettype wire

// File: tb/seq_checker_assertions.sv
`default_nettype none
module seq_checker
    import readout_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic level1_accept_in,
    input wire logic pipeline_read_enable_out,
    input wire logic shifter_load_out,
    input wire logic region_of_interest_read_enable_out,
    input wire logic region_of_interest_shifter_load_out,
    input wire logic [LINK_W-1:0] daq_link_data_out,
    input wire logic data_valid_strobe_n_out,
    input wire logic [LINK_W-1:0] region_of_interest_link_data_out,
    input wire logic region_of_interest_data_valid_strobe_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    logic [5:0] low_reg;
    logic [2:0] rd_reg;
    // Run lengths; counters keep the long repetitions out of the properties
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            low_reg <= 6'h00;
            rd_reg <= 3'h0;
        end else begin
            low_reg <= data_valid_strobe_n_out ? 6'h00 : low_reg + 6'h01;
            rd_reg <= pipeline_read_enable_out ? rd_reg + 3'h1 : 3'h0;
        end
    end
    property p_pad; region_of_interest_link_data_out[19:16] == 4'h0; endproperty
    a_pad: assert property (p_pad) else $error("region pad bits not zero");
    property p_idle; data_valid_strobe_n_out |-> daq_link_data_out == '0; endproperty
    a_idle: assert property (p_idle) else $error("link data outside frame");
    property p_start; $rose(pipeline_read_enable_out) |-> $past(level1_accept_in, 2); endproperty
    a_start: assert property (p_start) else $error("read without accept");
    property p_len; rd_reg <= 3'h5; endproperty
    a_len: assert property (p_len) else $error("read run too long");
    property p_load; $rose(pipeline_read_enable_out) |-> ##2 shifter_load_out; endproperty
    a_load: assert property (p_load) else $error("shifter load late");
    property p_first; $rose(pipeline_read_enable_out) |-> ##4 $fell(data_valid_strobe_n_out); endproperty
    a_first: assert property (p_first) else $error("frame start late");
    property p_frame; $rose(data_valid_strobe_n_out) |-> low_reg[2:0] == 3'h0 && low_reg <= 6'h28; endproperty
    a_frame: assert property (p_frame) else $error("frame not whole slices");
    property p_dead; $rose(data_valid_strobe_n_out) |-> data_valid_strobe_n_out [*5]; endproperty
    a_dead: assert property (p_dead) else $error("dead time too short");
    property p_roi; $fell(region_of_interest_data_valid_strobe_n_out) |->
        !region_of_interest_data_valid_strobe_n_out [*6] ##1 region_of_interest_data_valid_strobe_n_out; endproperty
    a_roi: assert property (p_roi) else $error("region frame length");
    property p_rrd; level1_accept_in |=> region_of_interest_read_enable_out; endproperty
    a_rrd: assert property (p_rrd) else $error("region read missing");
    property p_rload; region_of_interest_shifter_load_out |-> ##2 $fell(region_of_interest_data_valid_strobe_n_out);
    endproperty
    a_rload: assert property (p_rload) else $error("region frame late");
    c_five: cover property ($rose(data_valid_strobe_n_out) && low_reg == 6'h28);
    c_three: cover property ($rose(data_valid_strobe_n_out) && low_reg == 6'h18);
    c_roi: cover property ($fell(region_of_interest_data_valid_strobe_n_out));
endmodule
`default_nettype wire
